/* core/rssl_pkg.sv */
package rssl_pkg;

  // Register bus geometry
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          STAT_W        = 16;
  localparam int          SRC_W         = 8;
  localparam int          STRB_W        = 4;

  // Register byte addresses
  localparam logic [7:0]  STATUS_ADDR   = 8'h00;
  localparam logic [7:0]  SOURCE_ADDR   = 8'h04;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Status field positions
  localparam int          TRAP_BIT      = 15;
  localparam int          ILLOP_BIT     = 14;
  localparam int          CFGMIS_BIT    = 9;
  localparam int          PROGMEM_SLEEP_POWER_BIT     = 8;
  localparam int          PIN_BIT       = 7;
  localparam int          SOFT_BIT      = 6;
  localparam int          WDEN_BIT      = 5;
  localparam int          WATCHDOG_TIMEOUT_FLAG_BIT      = 4;
  localparam int          SLEEP_BIT     = 3;
  localparam int          IDLE_BIT      = 2;
  localparam int          BROWN_BIT     = 1;
  localparam int          POWER_BIT     = 0;

  // Status values and masks
  localparam logic [15:0] STATUS_POR    = 16'h0003;
  localparam logic [15:0] STATUS_IMPL   = 16'hC3FF;

  // Source snapshot positions
  localparam int          SRC_BROWN     = 0;
  localparam int          SRC_PIN       = 1;
  localparam int          SRC_SOFT      = 2;
  localparam int          SRC_WDT       = 3;
  localparam int          SRC_CFGMIS    = 4;
  localparam int          SRC_TRAP      = 5;
  localparam int          SRC_ILLOP     = 6;
  localparam int          SRC_UNINIT    = 7;

endpackage : rssl_pkg

/* core/rssl_core.sv */
`timescale 1ns/1ps

module rssl_core (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        brownout_reset,
  input  wire logic        master_clear_pin_n,
  input  wire logic        soft_reset_instr,
  input  wire logic        watchdog_timeout,
  input  wire logic        config_mismatch,
  input  wire logic        trap_conflict,
  input  wire logic        illegal_op,
  input  wire logic        uninit_wreg_reset,
  input  wire logic        power_save_sleep,
  input  wire logic        power_save_idle,
  input  wire logic        watchdog_clear_instr,
  input  wire logic        watchdog_fuse_enable,
  output logic             master_system_reset,
  output logic             watchdog_enable,
  output logic             progmem_sleep_power,
  output logic             regulator_standby,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);

  typedef struct packed {
    logic        master_clear_pin_meta;
    logic        master_clear_pin_sync;
    logic [15:0] status;
    logic [7:0]  src_snap;
    logic        sys_rst;
    logic        wdt_en;
    logic        pm_pwr;
    logic        reg_stby;
    logic        aw_held;
    logic [7:0]  awaddr;
    logic        awready;
    logic        w_held;
    logic [15:0] wdata;
    logic [1:0]  wstrb;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rssl_state_t;

  localparam rssl_state_t RSSL_RESET = '{
    master_clear_pin_meta: 1'b1,
    master_clear_pin_sync: 1'b1,
    status:    rssl_pkg::STATUS_POR,
    src_snap:  8'h00,
    sys_rst:   1'b1,
    wdt_en:    1'b1,
    pm_pwr:    1'b0,
    reg_stby:  1'b1,
    aw_held:   1'b0,
    awaddr:    8'h00,
    awready:   1'b1,
    w_held:    1'b0,
    wdata:     16'h0000,
    wstrb:     2'h0,
    wready:    1'b1,
    bvalid:    1'b0,
    bresp:     2'h0,
    arready:   1'b1,
    rvalid:    1'b0,
    rdata:     32'h0000_0000,
    rresp:     2'h0
  };

  rssl_state_t st;
  rssl_state_t next_st;
  logic        wr_fire;
  logic [15:0] hw_set;

  // Expands two byte strobes to a 16-bit bit mask
  function automatic logic [15:0] rssl_strb_mask(input logic [1:0] strb);
    rssl_strb_mask = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction : rssl_strb_mask

  // Read data for one register address
  function automatic logic [31:0] rssl_read_word(input logic [7:0]  addr,
                                                 input logic [15:0] status,
                                                 input logic [7:0]  snap);
    rssl_read_word = 32'h0000_0000;
    if (addr == rssl_pkg::STATUS_ADDR) begin
      rssl_read_word = {16'h0000, status & rssl_pkg::STATUS_IMPL};
    end else if (addr == rssl_pkg::SOURCE_ADDR) begin
      rssl_read_word = {24'h00_0000, snap};
    end
  endfunction : rssl_read_word

  always_comb begin
    next_st = st;
    hw_set  = 16'h0000;

    // Pin synchroniser
    next_st.master_clear_pin_meta = master_clear_pin_n;
    next_st.master_clear_pin_sync = st.master_clear_pin_meta;

    next_st.src_snap[rssl_pkg::SRC_BROWN]  = brownout_reset;
    next_st.src_snap[rssl_pkg::SRC_PIN]    = ~st.master_clear_pin_sync;
    next_st.src_snap[rssl_pkg::SRC_SOFT]   = soft_reset_instr;
    next_st.src_snap[rssl_pkg::SRC_WDT]    = watchdog_timeout;
    next_st.src_snap[rssl_pkg::SRC_CFGMIS] = config_mismatch;
    next_st.src_snap[rssl_pkg::SRC_TRAP]   = trap_conflict;
    next_st.src_snap[rssl_pkg::SRC_ILLOP]  = illegal_op;
    next_st.src_snap[rssl_pkg::SRC_UNINIT] = uninit_wreg_reset;

    next_st.sys_rst = brownout_reset | ~st.master_clear_pin_sync | soft_reset_instr
                    | watchdog_timeout | config_mismatch | trap_conflict
                    | illegal_op | uninit_wreg_reset;

    hw_set[rssl_pkg::TRAP_BIT]   = trap_conflict;
    hw_set[rssl_pkg::ILLOP_BIT]  = illegal_op | uninit_wreg_reset;
    hw_set[rssl_pkg::CFGMIS_BIT] = config_mismatch;
    hw_set[rssl_pkg::PIN_BIT]    = ~st.master_clear_pin_sync;
    hw_set[rssl_pkg::SOFT_BIT]   = soft_reset_instr;
    hw_set[rssl_pkg::WATCHDOG_TIMEOUT_FLAG_BIT]   = watchdog_timeout;
    hw_set[rssl_pkg::SLEEP_BIT]  = power_save_sleep;
    hw_set[rssl_pkg::IDLE_BIT]   = power_save_idle;
    hw_set[rssl_pkg::BROWN_BIT]  = brownout_reset;

    // Write address channel
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr  = s_axi_awaddr;
    end

    // Write data channel
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata  = s_axi_wdata[15:0];
      next_st.wstrb  = s_axi_wstrb[1:0];
    end

    // Write response
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    wr_fire = st.aw_held && st.w_held && !st.bvalid;
    if (wr_fire) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = rssl_pkg::RESP_SLVERR;
      if (st.awaddr == rssl_pkg::STATUS_ADDR) begin
        next_st.bresp = rssl_pkg::RESP_OKAY;
        next_st.status = (st.status & ~rssl_strb_mask(st.wstrb))
                       | (st.wdata & rssl_strb_mask(st.wstrb));
      end
    end

    if (power_save_sleep || power_save_idle || watchdog_clear_instr) begin
      next_st.status[rssl_pkg::WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b0;
    end

    next_st.status = next_st.status | hw_set;
    next_st.status = next_st.status & rssl_pkg::STATUS_IMPL;

    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready  = !next_st.w_held && !next_st.bvalid;

    // Read channel
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rssl_read_word(s_axi_araddr, st.status, st.src_snap);
      if (s_axi_araddr == rssl_pkg::STATUS_ADDR ||
          s_axi_araddr == rssl_pkg::SOURCE_ADDR) begin
        next_st.rresp = rssl_pkg::RESP_OKAY;
      end else begin
        next_st.rresp = rssl_pkg::RESP_SLVERR;
      end
    end
    next_st.arready = !next_st.rvalid;

    next_st.wdt_en   = watchdog_fuse_enable | next_st.status[rssl_pkg::WDEN_BIT];
    next_st.pm_pwr   = next_st.status[rssl_pkg::PROGMEM_SLEEP_POWER_BIT];
    next_st.reg_stby = !next_st.status[rssl_pkg::PROGMEM_SLEEP_POWER_BIT];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= RSSL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign master_system_reset = st.sys_rst;
  assign watchdog_enable     = st.wdt_en;
  assign progmem_sleep_power = st.pm_pwr;
  assign regulator_standby   = st.reg_stby;
  assign s_axi_awready       = st.awready;
  assign s_axi_wready        = st.wready;
  assign s_axi_bvalid        = st.bvalid;
  assign s_axi_bresp         = st.bresp;
  assign s_axi_arready       = st.arready;
  assign s_axi_rvalid        = st.rvalid;
  assign s_axi_rdata         = st.rdata;
  assign s_axi_rresp         = st.rresp;

  default clocking rssl_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  AST_MASTER_RESET: assert property (
    (brownout_reset || soft_reset_instr || watchdog_timeout || config_mismatch ||
     trap_conflict || illegal_op || uninit_wreg_reset) |=> master_system_reset)
    else $error("Reset source did not assert master reset");

  AST_TRAP_FLAG: assert property (
    trap_conflict |=> st.status[rssl_pkg::TRAP_BIT])
    else $error("Trap conflict flag not set");

  AST_ILLOP_FLAG: assert property (
    (illegal_op || uninit_wreg_reset) |=> st.status[rssl_pkg::ILLOP_BIT])
    else $error("Illegal op flag not set");

  AST_UNIMPL_ZERO: assert property (
    s_axi_rvalid && s_axi_rresp == rssl_pkg::RESP_OKAY |-> s_axi_rdata[13:10] == 4'h0)
    else $error("Unimplemented bits read nonzero");

  AST_CFGMIS_FLAG: assert property (
    config_mismatch |=> st.status[rssl_pkg::CFGMIS_BIT])
    else $error("Mismatch flag not set");

  AST_PROGMEM_SLEEP_POWER_OUT: assert property (
    progmem_sleep_power != regulator_standby)
    else $error("Bias and standby outputs agree");

  AST_PIN_FLAG: assert property (
    !master_clear_pin_n |-> ##3 (st.status[rssl_pkg::PIN_BIT] && master_system_reset))
    else $error("Pin reset not seen three cycles after pin");

  AST_SOFT_FLAG: assert property (
    soft_reset_instr |=> st.status[rssl_pkg::SOFT_BIT])
    else $error("Soft reset flag not set");

  AST_WDT_FUSE: assert property (
    watchdog_fuse_enable |=> watchdog_enable)
    else $error("Fuse did not force watchdog");

  AST_WATCHDOG_TIMEOUT_FLAG_CLEAR: assert property (
    watchdog_clear_instr && !watchdog_timeout && !wr_fire
    |=> !st.status[rssl_pkg::WATCHDOG_TIMEOUT_FLAG_BIT])
    else $error("Watchdog clear did not clear timeout flag");

  AST_SLEEP_FLAG: assert property (
    power_save_sleep |=> st.status[rssl_pkg::SLEEP_BIT])
    else $error("Sleep flag not set");

  AST_IDLE_FLAG: assert property (
    power_save_idle |=> st.status[rssl_pkg::IDLE_BIT])
    else $error("Idle flag not set");

  AST_BROWN_FLAG: assert property (
    brownout_reset |=> st.status[rssl_pkg::BROWN_BIT])
    else $error("Brownout flag not set");

  AST_POWER_HOLD: assert property (
    !wr_fire && st.status[rssl_pkg::POWER_BIT] |=> st.status[rssl_pkg::POWER_BIT])
    else $error("Power flag cleared by hardware");

  AST_WRITE_NO_RESET: assert property (
    wr_fire && master_clear_pin_n && !next_st.sys_rst ##1 master_clear_pin_n
    |-> !master_system_reset)
    else $error("Software write caused reset");

  AST_SET_WINS: assert property (
    wr_fire && trap_conflict |=> st.status[rssl_pkg::TRAP_BIT])
    else $error("Software write beat hardware set");

  AST_WRITE_RESP: assert property (
    wr_fire |=> s_axi_bvalid)
    else $error("Write response missing");

  AST_WDT_SOFT: assert property (
    !watchdog_fuse_enable |=> watchdog_enable == st.status[rssl_pkg::WDEN_BIT])
    else $error("Watchdog enable does not follow software bit");

  AST_WATCHDOG_TIMEOUT_FLAG_SET_WINS: assert property (
    watchdog_timeout && (power_save_sleep || power_save_idle || watchdog_clear_instr)
    |=> st.status[rssl_pkg::WATCHDOG_TIMEOUT_FLAG_BIT])
    else $error("Clear instruction beat watchdog timeout");

  AST_READ_STATUS: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == rssl_pkg::STATUS_ADDR
    |=> s_axi_rdata[15:0] == $past(st.status))
    else $error("Status read data wrong");

  AST_POWER_NO_SET: assert property (
    !wr_fire && !st.status[rssl_pkg::POWER_BIT] |=> !st.status[rssl_pkg::POWER_BIT])
    else $error("Power flag set by hardware");

  AST_BROWN_HOLD: assert property (
    !wr_fire && st.status[rssl_pkg::BROWN_BIT] |=> st.status[rssl_pkg::BROWN_BIT])
    else $error("Brownout flag cleared by hardware");

  AST_TRAP_HOLD: assert property (
    !wr_fire && st.status[rssl_pkg::TRAP_BIT] |=> st.status[rssl_pkg::TRAP_BIT])
    else $error("Trap flag cleared by hardware");

  COV_PIN_RESET: cover property (!master_clear_pin_n ##3 master_system_reset);
  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
  COV_READ: cover property (s_axi_rvalid && s_axi_rready);
  COV_WDT_TIMEOUT: cover property (watchdog_timeout ##1 master_system_reset);
  COV_SET_WINS: cover property (wr_fire && trap_conflict);

endmodule : rssl_core

/* test/rssl_src_model.sv */
`timescale 1ns/1ps

// Reset sources and instruction strobes of the core side, one cycle after cmd
module rssl_src_model (
  input  wire logic        ref_clk,
  input  wire logic [10:0] cmd,
  output logic             brownout_reset       = 1'b0,
  output logic             master_clear_pin_n   = 1'b1,
  output logic             soft_reset_instr     = 1'b0,
  output logic             watchdog_timeout     = 1'b0,
  output logic             config_mismatch      = 1'b0,
  output logic             trap_conflict        = 1'b0,
  output logic             illegal_op           = 1'b0,
  output logic             uninit_wreg_reset    = 1'b0,
  output logic             power_save_sleep     = 1'b0,
  output logic             power_save_idle      = 1'b0,
  output logic             watchdog_clear_instr = 1'b0
);
  // each source drives its own line
  always @(posedge ref_clk) begin
    brownout_reset       <= cmd[0];
    master_clear_pin_n   <= ~cmd[1];
    soft_reset_instr     <= cmd[2];
    watchdog_timeout     <= cmd[3];
    config_mismatch      <= cmd[4];
    trap_conflict        <= cmd[5];
    illegal_op           <= cmd[6];
    uninit_wreg_reset    <= cmd[7];
    power_save_sleep     <= cmd[8];
    power_save_idle      <= cmd[9];
    watchdog_clear_instr <= cmd[10];
  end
endmodule : rssl_src_model

/* test/rssl_core_tb.sv */
`timescale 1ns/1ps

module rssl_core_tb;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        fuse = 1'b0;
  logic [10:0] cmd = '0;
  logic        awv = 1'b0, awr, wv = 1'b0, wr, bv, br = 1'b0, arv = 1'b0, arr, rv, rr = 1'b0;
  logic [7:0]  awa = '0, ara = '0;
  logic [31:0] wd = '0, rd;
  logic [1:0]  bresp, rresp, resp;
  logic        msr, wden, pmsp, rstb;
  logic        b0, b1, b2, b3, b4, b5, b6, b7, b8, b9, b10;
  logic [31:0] got, rnd;
  int          errors = 0, cmp_count = 0, cyc = 0, seed = 78, model, i;
  int          bitpos [11] = '{1, 7, 6, 4, 9, 15, 14, 14, 3, 2, 4};

  initial forever #25 ref_clk = ~ref_clk;

  rssl_src_model i_rssl_src_model (.ref_clk(ref_clk), .cmd(cmd), .brownout_reset(b0),
    .master_clear_pin_n(b1), .soft_reset_instr(b2), .watchdog_timeout(b3),
    .config_mismatch(b4), .trap_conflict(b5), .illegal_op(b6), .uninit_wreg_reset(b7),
    .power_save_sleep(b8), .power_save_idle(b9), .watchdog_clear_instr(b10));

  rssl_core i_rssl_core (.ref_clk(ref_clk), .rst_n(rst_n), .brownout_reset(b0),
    .master_clear_pin_n(b1), .soft_reset_instr(b2), .watchdog_timeout(b3),
    .config_mismatch(b4), .trap_conflict(b5), .illegal_op(b6), .uninit_wreg_reset(b7),
    .power_save_sleep(b8), .power_save_idle(b9), .watchdog_clear_instr(b10),
    .watchdog_fuse_enable(fuse), .master_system_reset(msr), .watchdog_enable(wden),
    .progmem_sleep_power(pmsp), .regulator_standby(rstb), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp));

  task final_report;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // Cuts a hang short
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      final_report();
    end
  end

  task chk_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk_word

  task chk_bit(input string what, input logic exp, input logic seen);
    chk_word(what, {31'h0, exp}, {31'h0, seen});
  endtask : chk_bit

  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    br <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge ref_clk);
      if (!aw_done && awr === 1'b1) begin
        aw_done = 1'b1;
        awv <= 1'b0;
      end
      if (!w_done && wr === 1'b1) begin
        w_done = 1'b1;
        wv <= 1'b0;
      end
    end
    while (bv !== 1'b1) @(posedge ref_clk);
    resp = bresp;
    br <= 1'b0;
    @(posedge ref_clk);
  endtask : axi_wr

  task axi_rd(input logic [7:0] a, output logic [31:0] d);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    do @(posedge ref_clk); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge ref_clk);
    d = rd;
    resp = rresp;
    rr <= 1'b0;
    @(posedge ref_clk);
  endtask : axi_rd

  task do_reset;
    rst_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    model = 32'h0003;
  endtask : do_reset

  // One source pulse; the master reset is watched for six cycles
  task pulse(input int k);
    logic seen;
    seen = 1'b0;
    cmd <= 11'h001 << k;
    @(posedge ref_clk);
    cmd <= '0;
    repeat (6) begin
      @(posedge ref_clk);
      seen = seen | msr;
    end
    chk_bit("master reset", k < 8, seen);
    if (k == 8 || k == 9 || k == 10) model = model & ~32'h0010;
    if (k != 10) model = model | (32'h1 << bitpos[k]);
    axi_rd(8'h00, got);
    chk_word("status after event", model, got);
  endtask : pulse

  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    model = 32'h0003;
    axi_rd(8'h00, got);
    chk_word("status at power-on", 32'h0003, got);
    cmd <= 11'h001;
    repeat (3) @(posedge ref_clk);
    axi_rd(8'h04, got);
    cmd <= '0;
    chk_word("source snapshot", 32'h0000_0001, got);
    for (i = 0; i < 11; i++) pulse(i);
    pulse(3);
    pulse(10);
    cmd <= 11'h408;
    @(posedge ref_clk);
    cmd <= '0;
    repeat (3) @(posedge ref_clk);
    model = model | 32'h0010;
    axi_rd(8'h00, got);
    chk_word("timeout beats clear", model, got);
    $display("test sources done");
    repeat (6) begin
      rnd = $random(seed);
      fuse <= rnd[20];
      axi_wr(8'h00, rnd);
      chk_word("write resp", 32'(rssl_pkg::RESP_OKAY), 32'(resp));
      model = rnd & 32'h0000C3FF;
      axi_rd(8'h00, got);
      chk_word("status written", model, got);
      chk_bit("no reset from write", 1'b0, msr);
      chk_bit("sleep power", rnd[8], pmsp);
      chk_bit("standby", ~rnd[8], rstb);
      chk_bit("watchdog enable", rnd[5] | fuse, wden);
    end
    $display("test writes done");
    // one-cycle source meets the write in the same cycle
    cmd <= 11'h020;
    fork
      axi_wr(8'h00, 32'h0000_0000);
      begin
        @(posedge ref_clk);
        cmd <= '0;
      end
    join
    axi_rd(8'h00, got);
    chk_word("set beats write", 32'h8000, got & 32'h8000);
    axi_wr(8'h00, 32'h0000_0000);
    model = 32'h0000;
    axi_rd(8'h00, got);
    chk_word("status cleared", model, got);
    axi_rd(8'h08, got);
    chk_word("unmapped resp", 32'(rssl_pkg::RESP_SLVERR), 32'(resp));
    chk_word("unmapped data", 32'h0, got);
    axi_wr(8'h04, 32'hFFFF_FFFF);
    chk_word("read-only resp", 32'(rssl_pkg::RESP_SLVERR), 32'(resp));
    $display("test bus done");
    pulse(2);
    do_reset();
    axi_rd(8'h00, got);
    chk_word("status after second reset", 32'h0003, got);
    $display("test reset done");
    final_report();
  end
endmodule : rssl_core_tb
